//--- src/pcs_fabric_pkg.sv
// constants and layout for the fabric data interface
// What this block does
// - rx bus: four 10-bit lanes, disparity/control/byte
// - raw mode: each lane carries whole code group
// - only lanes inside active width are valid
// - lane 0 holds earliest byte, ascending order
// - rx error and skip flags align per lane
// - non-byte status stays up at least one cycle
// - gearing splits 4-byte words into 2-byte words
// - gearing splits 2-byte words into single bytes
// - fifo flags overflow and underflow one cycle after the event, sticky until cleared
// - bypass captures fabric data in one flop
// - fifo mode latency is larger and variable
// - bypass adds no lane-to-lane skew
// - deskew aligns bonded channels' fifo read start
// - rx disparity bit: 1 positive, 0 negative
// - force/value bits select forced or inverted disparity
package pcs_fabric_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 10;
  localparam int BUS_W = 40;
  localparam int ENTRY_LANE_W = 13;
  localparam int ENTRY_W = 52;
  localparam int FIFO_DEPTH = 8;
  localparam int PTR_W = 4;
  localparam logic [PTR_W-1:0] PRIME_LEVEL = 4'h2;

  // register offsets
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 8'h04;

  // control fields
  localparam int CTL_WIDTH_LO = 0;
  localparam int CTL_RAW = 2;
  localparam int CTL_GEAR = 3;
  localparam int CTL_BYPASS = 4;
  localparam int CTL_DESKEW = 5;
  localparam int CTL_RUN = 6;
  localparam logic [6:0] CTRL_RESET = 7'h02;

  // status fields
  localparam int STAT_OVF = 0;
  localparam int STAT_UNF = 1;
  localparam int STAT_EMPTY = 2;
  localparam int STAT_FULL = 3;
  localparam int STAT_LEVEL_LO = 4;

  // bus width modes
  localparam logic [1:0] WIDTH_1B = 2'h0;
  localparam logic [1:0] WIDTH_2B = 2'h1;
  localparam logic [1:0] WIDTH_4B = 2'h2;

  typedef enum logic [1:0] {RD_IDLE, RD_WAIT_ALIGN, RD_RUN} rd_state_e;
endpackage

//--- src/pcs_fabric_data_interface.sv
// fabric side data interface: rx lane mapping, tx fifo, gearing, bypass
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module pcs_fabric_data_interface (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register port
  input wire logic [pcs_fabric_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pcs_fabric_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pcs_fabric_pkg::DATA_W-1:0] reg_rdata,
  // fabric transmit side
  input wire logic [pcs_fabric_pkg::BUS_W-1:0] tx_data,
  input wire logic [pcs_fabric_pkg::LANES-1:0] tx_frcdisp,
  input wire logic [pcs_fabric_pkg::LANES-1:0] tx_dispval,
  input wire logic [pcs_fabric_pkg::LANES-1:0] tx_frcdata,
  input wire logic tx_valid,
  output logic tx_word_en,
  output logic tx_fifo_empty,
  output logic tx_fifo_full,
  output logic tx_overflow,
  output logic tx_underflow,
  // multi-channel alignment
  input wire logic deskew_go,
  output logic deskew_ready,
  // coding sublayer transmit side
  output logic [pcs_fabric_pkg::BUS_W-1:0] core_tx_data,
  output logic [pcs_fabric_pkg::LANES-1:0] core_tx_frcdisp,
  output logic [pcs_fabric_pkg::LANES-1:0] core_tx_dispval,
  output logic [pcs_fabric_pkg::LANES-1:0] core_tx_frcdata,
  output logic core_tx_valid,
  // coding sublayer receive side
  input wire logic [31:0] core_rx_byte,
  input wire logic [pcs_fabric_pkg::LANES-1:0] core_rx_ctrl,
  input wire logic [pcs_fabric_pkg::LANES-1:0] core_rx_rundisp,
  input wire logic [pcs_fabric_pkg::BUS_W-1:0] core_rx_raw,
  input wire logic [pcs_fabric_pkg::LANES-1:0] core_rx_errdisp,
  input wire logic [pcs_fabric_pkg::LANES-1:0] core_rx_errcode,
  input wire logic [pcs_fabric_pkg::LANES-1:0] core_rx_skp_add,
  input wire logic [pcs_fabric_pkg::LANES-1:0] core_rx_skp_del,
  input wire logic core_rx_valid,
  // fabric receive side
  output logic [pcs_fabric_pkg::BUS_W-1:0] rx_data,
  output logic [pcs_fabric_pkg::LANES-1:0] rx_errdisp,
  output logic [pcs_fabric_pkg::LANES-1:0] rx_errcode,
  output logic [pcs_fabric_pkg::LANES-1:0] skp_add,
  output logic [pcs_fabric_pkg::LANES-1:0] skp_del,
  output logic rx_valid
);
  import pcs_fabric_pkg::*;

  logic [6:0] ctrl;
  logic [1:0] cfg_width;
  logic cfg_raw;
  logic cfg_gear;
  logic cfg_bypass;
  logic cfg_deskew;
  logic cfg_run;
  logic gear_active;
  logic gear_wide;
  logic phase;
  rd_state_e rd_state;
  logic [ENTRY_W-1:0] mem [FIFO_DEPTH];
  logic [ENTRY_W-1:0] hold;
  logic [ENTRY_W-1:0] in_word;
  logic [ENTRY_W-1:0] head;
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W-1:0] level;
  logic empty;
  logic full;
  logic push_req;
  logic push;
  logic need_word;
  logic take_word;
  logic pop;
  logic ovf_evt;
  logic unf_evt;
  logic clr_ovf;
  logic clr_unf;
  logic running;
  logic [LANES-1:0] rx_mask;
  logic [LANES-1:0] out_mask;
  logic [ENTRY_W-1:0] next_out;

  function automatic logic lane_on(input logic [1:0] width, input int k);
    case (width)
      WIDTH_1B: lane_on = (k < 1);
      WIDTH_2B: lane_on = (k < 2);
      default: lane_on = 1'b1;
    endcase
  endfunction

  assign cfg_width = ctrl[CTL_WIDTH_LO +: 2];
  assign cfg_raw = ctrl[CTL_RAW];
  assign cfg_gear = ctrl[CTL_GEAR];
  assign cfg_bypass = ctrl[CTL_BYPASS];
  assign cfg_deskew = ctrl[CTL_DESKEW];
  assign cfg_run = ctrl[CTL_RUN];
  // gearing on a 1-byte bus has nothing to split
  assign gear_active = cfg_gear && (cfg_width != WIDTH_1B);
  assign gear_wide = cfg_width != WIDTH_1B && cfg_width != WIDTH_2B;
  assign running = rd_state == RD_RUN;

  // register port
  assign clr_ovf = reg_wr && reg_addr == STAT_ADDR && reg_wdata[STAT_OVF];
  assign clr_unf = reg_wr && reg_addr == STAT_ADDR && reg_wdata[STAT_UNF];

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= CTRL_RESET;
    end else if (reg_wr && reg_addr == CTRL_ADDR) begin
      ctrl <= reg_wdata[6:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd && reg_addr == CTRL_ADDR) begin
      reg_rdata <= {25'h000_0000, ctrl};
    end else if (reg_rd && reg_addr == STAT_ADDR) begin
      reg_rdata <= {24'h00_0000, level, tx_fifo_full, tx_fifo_empty, tx_underflow, tx_overflow};
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // receive lane mapping, one flop stage so flags stay with their byte
  genvar k;
  generate
    for (k = 0; k < LANES; k++) begin : g_rx
      assign rx_mask[k] = lane_on(cfg_width, k);
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          rx_data[k*LANE_W +: LANE_W] <= 10'h000;
          rx_errdisp[k] <= 1'b0;
          rx_errcode[k] <= 1'b0;
          skp_add[k] <= 1'b0;
          skp_del[k] <= 1'b0;
        end else if (core_rx_valid && rx_mask[k]) begin
          if (cfg_raw) begin
            rx_data[k*LANE_W +: LANE_W] <= core_rx_raw[k*LANE_W +: LANE_W];
          end else begin
            rx_data[k*LANE_W +: LANE_W] <=
              {core_rx_rundisp[k], core_rx_ctrl[k], core_rx_byte[k*8 +: 8]};
          end
          rx_errdisp[k] <= core_rx_errdisp[k];
          rx_errcode[k] <= core_rx_errcode[k];
          skp_add[k] <= core_rx_skp_add[k];
          skp_del[k] <= core_rx_skp_del[k];
        end else begin
          rx_data[k*LANE_W +: LANE_W] <= 10'h000;
          rx_errdisp[k] <= 1'b0;
          rx_errcode[k] <= 1'b0;
          skp_add[k] <= 1'b0;
          skp_del[k] <= 1'b0;
        end
      end
      // force controls ride in the same entry as their byte
      assign in_word[k*ENTRY_LANE_W +: ENTRY_LANE_W] =
        {tx_frcdata[k], tx_dispval[k], tx_frcdisp[k], tx_data[k*LANE_W +: LANE_W]};
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= core_rx_valid;
    end
  end

  // gearing divider: fabric supplies one word every other cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      phase <= 1'b0;
      tx_word_en <= 1'b1;
    end else begin
      phase <= gear_active ? ~phase : 1'b0;
      tx_word_en <= !gear_active || !phase;
    end
  end

  // phase compensation fifo
  assign level = wr_ptr - rd_ptr;
  assign empty = level == 4'h0;
  assign full = level == 4'(FIFO_DEPTH);
  assign push_req = tx_valid && tx_word_en && !cfg_bypass;
  assign push = push_req && !full;
  assign ovf_evt = push_req && full;
  assign need_word = running && (!gear_active || !phase);
  assign take_word = running && (!gear_active || phase);
  assign pop = take_word && !cfg_bypass && !empty;
  assign unf_evt = need_word && !cfg_bypass && empty;
  assign head = cfg_bypass ? hold : mem[rd_ptr[PTR_W-2:0]];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr[PTR_W-2:0]] <= in_word;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
    end else if (!cfg_run && rd_state == RD_IDLE && cfg_bypass) begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 4'h1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 4'h1;
      end
    end
  end

  // bypass: a single capture stage, fixed latency, no added skew
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hold <= '0;
    end else if (cfg_bypass && tx_valid && tx_word_en) begin
      hold <= in_word;
    end
  end

  // sticky error flags, an event in a clear cycle wins
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_overflow <= 1'b0;
      tx_underflow <= 1'b0;
    end else begin
      tx_overflow <= ovf_evt || (tx_overflow && !clr_ovf);
      tx_underflow <= unf_evt || (tx_underflow && !clr_unf);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_fifo_empty <= 1'b1;
      tx_fifo_full <= 1'b0;
      deskew_ready <= 1'b0;
    end else begin
      tx_fifo_empty <= empty;
      tx_fifo_full <= full;
      deskew_ready <= level >= PRIME_LEVEL;
    end
  end

  // read start; with deskew outside bypass all bonded channels start on one common pulse
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_state <= RD_IDLE;
    end else begin
      case (rd_state)
        RD_IDLE: begin
          if (cfg_run && (!gear_active || phase)) begin
            if (cfg_bypass) begin
              rd_state <= RD_RUN;
            end else if (level >= PRIME_LEVEL) begin
              rd_state <= cfg_deskew ? RD_WAIT_ALIGN : RD_RUN;
            end
          end
        end
        RD_WAIT_ALIGN: begin
          if (!cfg_run) begin
            rd_state <= RD_IDLE;
          end else if (deskew_go && (!gear_active || phase)) begin
            rd_state <= RD_RUN;
          end
        end
        RD_RUN: begin
          if (!cfg_run) begin
            rd_state <= RD_IDLE;
          end
        end
        default: rd_state <= RD_IDLE;
      endcase
    end
  end

  // output lane selection; geared words send the low lanes first
  generate
    for (k = 0; k < LANES; k++) begin : g_tx
      logic [1:0] src;
      always_comb begin
        if (gear_active && gear_wide) begin
          out_mask[k] = k < 2;
          src = 2'(k) + {phase, 1'b0};
        end else if (gear_active) begin
          out_mask[k] = k == 0;
          src = {1'b0, phase};
        end else begin
          out_mask[k] = lane_on(cfg_width, k);
          src = 2'(k);
        end
        next_out[k*ENTRY_LANE_W +: ENTRY_LANE_W] = out_mask[k] ?
          head[src*ENTRY_LANE_W +: ENTRY_LANE_W] : 13'h0000;
      end
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          core_tx_data[k*LANE_W +: LANE_W] <= 10'h000;
          core_tx_frcdisp[k] <= 1'b0;
          core_tx_dispval[k] <= 1'b0;
          core_tx_frcdata[k] <= 1'b0;
        end else if (running && (cfg_bypass || !empty)) begin
          core_tx_data[k*LANE_W +: LANE_W] <= next_out[k*ENTRY_LANE_W +: LANE_W];
          core_tx_frcdisp[k] <= next_out[k*ENTRY_LANE_W + 10];
          core_tx_dispval[k] <= next_out[k*ENTRY_LANE_W + 11];
          core_tx_frcdata[k] <= next_out[k*ENTRY_LANE_W + 12];
        end else begin
          core_tx_data[k*LANE_W +: LANE_W] <= 10'h000;
          core_tx_frcdisp[k] <= 1'b0;
          core_tx_dispval[k] <= 1'b0;
          core_tx_frcdata[k] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      core_tx_valid <= 1'b0;
    end else begin
      core_tx_valid <= running && (cfg_bypass || !empty);
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  AST_RX_DECODED: assert property (
    core_rx_valid && !cfg_raw |=> rx_data[8] == $past(core_rx_ctrl[0])
      && rx_data[7:0] == $past(core_rx_byte[7:0]))
    else $error("decoded lane 0 layout wrong");
  AST_RX_RUNDISP: assert property (
    core_rx_valid && !cfg_raw |=> rx_data[9] == $past(core_rx_rundisp[0]))
    else $error("running disparity bit wrong");
  AST_RX_RAW: assert property (
    core_rx_valid && cfg_raw |=> rx_data[9:0] == $past(core_rx_raw[9:0]))
    else $error("raw lane 0 not passed whole");
  AST_RX_WIDTH: assert property (
    cfg_width == WIDTH_1B |=> rx_data[39:10] == 30'h0000_0000 && rx_errcode[3:1] == 3'h0)
    else $error("unused rx lanes not zero");
  AST_RX_FLAGS: assert property (
    core_rx_valid |=> rx_errdisp == ($past(core_rx_errdisp) & $past(rx_mask))
      && skp_del == ($past(core_rx_skp_del) & $past(rx_mask)))
    else $error("rx flags not aligned with data");
  AST_OVF_SET: assert property (
    ovf_evt |=> tx_overflow)
    else $error("overflow not flagged");
  AST_UNF_HOLD: assert property (
    $rose(tx_underflow) && !clr_unf |=> tx_underflow)
    else $error("underflow flag lasted one cycle");
  AST_GEAR_WIDE: assert property (
    gear_active && gear_wide && core_tx_valid |-> core_tx_data[39:20] == 20'h0_0000)
    else $error("geared 4-byte output exceeds two lanes");
  AST_GEAR_ORDER: assert property (
    gear_active && !gear_wide && running && !phase && !cfg_bypass && !empty
      |=> core_tx_data[9:0] == $past(mem[rd_ptr[PTR_W-2:0]][9:0])
      ##1 core_tx_data[9:0] == $past(mem[rd_ptr[PTR_W-2:0]][22:13], 2))
    else $error("geared bytes out of lane order");
  AST_BYPASS_LAT: assert property (
    cfg_bypass && !gear_active && running && tx_valid && $stable(cfg_bypass)
      |=> ##1 core_tx_data == $past(tx_data, 2))
    else $error("bypass latency not fixed");
  AST_DESKEW_GO: assert property (
    rd_state == RD_WAIT_ALIGN && !deskew_go |=> rd_state != RD_RUN)
    else $error("read started without alignment pulse");
endmodule
`default_nettype wire

//--- tb/fabric_tx_model.sv
// fabric user logic model: random tx words with their lane controls
`timescale 1ns/10ps
`default_nettype none
module fabric_tx_model (
  // clock and control
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic en,
  input wire logic tx_word_en,
  // tx word
  output logic [39:0] tx_data,
  output logic [3:0] tx_frcdisp,
  output logic [3:0] tx_dispval,
  output logic [3:0] tx_frcdata,
  output logic tx_valid
);
  // shares clk_sys with the block, so no drift can build up
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_valid <= 1'h0;
      {tx_data, tx_frcdisp, tx_dispval, tx_frcdata} <= '0;
    end else if (tx_word_en) begin
      // a word is only withdrawn once taken
      tx_valid <= en;
      tx_data <= en ? {8'($urandom), $urandom} : ~tx_data;
      {tx_frcdisp, tx_dispval, tx_frcdata} <= 12'($urandom);
    end
  end
endmodule
`default_nettype wire

//--- tb/pcs_fabric_data_interface_tb.sv
// self-checking bench for the fabric data interface
`timescale 1ns/10ps
`default_nettype none
module pcs_fabric_data_interface_tb;
  import pcs_fabric_pkg::*;
  logic clk_sys = 1'h0;
  logic rst_b, reg_wr, reg_rd, tx_valid, tx_word_en, deskew_go, deskew_ready, src_en;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, core_rx_byte;
  logic [39:0] tx_data, core_tx_data, core_rx_raw, rx_data;
  logic [3:0] tx_frcdisp, tx_dispval, tx_frcdata, c_fd, c_dv, c_fr;
  logic [3:0] core_rx_ctrl, core_rx_rundisp, r_ed, r_ec, r_sa, r_sd;
  logic [3:0] rx_errdisp, rx_errcode, skp_add, skp_del;
  logic core_tx_valid, core_rx_valid, rx_valid, t_ov, t_un, t_em, t_fu, gear, byp, raw_mode;
  logic [1:0] wmode;
  logic [51:0] hm, hd;
  logic [51:0] txq[$];
  logic [55:0] rxq[$];
  int error_cnt = 0;
  int n_tests = 0;
  int bcnt = 0;

  always #50 clk_sys = ~clk_sys;

  pcs_fabric_data_interface dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_data(tx_data), .tx_frcdisp(tx_frcdisp), .tx_dispval(tx_dispval),
    .tx_frcdata(tx_frcdata), .tx_valid(tx_valid), .tx_word_en(tx_word_en),
    .tx_fifo_empty(t_em), .tx_fifo_full(t_fu), .tx_overflow(t_ov), .tx_underflow(t_un),
    .deskew_go(deskew_go), .deskew_ready(deskew_ready), .core_tx_data(core_tx_data),
    .core_tx_frcdisp(c_fd), .core_tx_dispval(c_dv), .core_tx_frcdata(c_fr),
    .core_tx_valid(core_tx_valid), .core_rx_byte(core_rx_byte), .core_rx_ctrl(core_rx_ctrl),
    .core_rx_rundisp(core_rx_rundisp), .core_rx_raw(core_rx_raw), .core_rx_errdisp(r_ed),
    .core_rx_errcode(r_ec), .core_rx_skp_add(r_sa), .core_rx_skp_del(r_sd),
    .core_rx_valid(core_rx_valid), .rx_data(rx_data), .rx_errdisp(rx_errdisp),
    .rx_errcode(rx_errcode), .skp_add(skp_add), .skp_del(skp_del), .rx_valid(rx_valid));

  fabric_tx_model src (.clk_sys(clk_sys), .rst_b(rst_b), .en(src_en), .tx_word_en(tx_word_en),
    .tx_data(tx_data), .tx_frcdisp(tx_frcdisp), .tx_dispval(tx_dispval),
    .tx_frcdata(tx_frcdata), .tx_valid(tx_valid));

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [55:0] e, logic [55:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1;
    chk("reg_rdata", 56'(e), 56'(reg_rdata));
  endtask

  task automatic ctrl(logic [7:0] c);
    wmode = c[1:0];
    gear = c[CTL_GEAR];
    byp = c[CTL_BYPASS];
    wr(CTRL_ADDR, 32'(c));
  endtask

  task automatic wait_tx(int n, bit fill);
    int i;
    for (i = 0; i < 300 && (fill ? txq.size() < n : txq.size() != 0); i++) @(posedge clk_sys);
    if (i == 300) begin
      error_cnt++;
      $display("[ERR] tx_queue expected %0d seen %0d", n, txq.size());
      results();
    end
  endtask

  // expected rx word: lanes past the width read zero with no flags
  task automatic rx_burst(int n);
    logic [55:0] e;
    logic [39:0] r;
    logic [31:0] b;
    logic [15:0] fl;
    logic [7:0] c4;
    logic [3:0] m;
    int nl;
    nl = (wmode == WIDTH_1B) ? 1 : (wmode == WIDTH_2B) ? 2 : 4;
    m = 4'((1 << nl) - 1);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      b = $urandom;
      r = {8'($urandom), $urandom};
      fl = 16'($urandom);
      c4 = 8'($urandom);
      core_rx_byte <= b;
      core_rx_raw <= r;
      {core_rx_ctrl, core_rx_rundisp} <= c4;
      {r_ed, r_ec, r_sa, r_sd} <= fl;
      core_rx_valid <= (i % 5) != 4;
      e = {40'h0, fl & {4{m}}};
      for (int k = 0; k < nl; k++) begin
        e[16+10*k +: 10] = raw_mode ? r[10*k +: 10] : {c4[k], c4[4+k], b[8*k +: 8]};
      end
      if ((i % 5) != 4) rxq.push_back(e);
    end
    @(posedge clk_sys);
    core_rx_valid <= 1'h0;
  endtask

  // fifo pass: prime, start reading, drain, then starve it
  task automatic tx_run(logic [7:0] c, int n);
    int n0;
    ctrl(c);
    src_en <= 1'h1;
    wait_tx(n, 1);
    src_en <= 1'h0;
    repeat (4) @(posedge clk_sys);
    n0 = tx_word_en;
    @(posedge clk_sys);
    chk("tx_word_en", c[CTL_GEAR] ? 56'h1 : 56'h2, 56'(n0 + tx_word_en));
    ctrl(c | 8'h40);
    if (c[CTL_DESKEW]) begin
      n0 = txq.size();
      repeat (4) @(posedge clk_sys);
      chk("deskew_hold", 56'(n0), 56'(txq.size()));
      chk("deskew_ready", 56'h1, 56'(deskew_ready));
      deskew_go <= 1'h1;
      @(posedge clk_sys);
      deskew_go <= 1'h0;
    end
    wait_tx(0, 0);
    repeat (3) @(posedge clk_sys);
    rd(STAT_ADDR, 32'h6);
    chk("tx_flags", 56'h6, 56'({t_fu, t_em, t_un, t_ov}));
    ctrl(c);
    wr(STAT_ADDR, 32'h2);
    rd(STAT_ADDR, 32'h4);
    $display("test tx mode %h done", c);
  endtask

  // words the block takes, as they should leave the fifo
  always @(posedge clk_sys) begin
    if (tx_valid === 1'h1 && tx_word_en === 1'h1 && !byp) begin
      if (!gear) txq.push_back({tx_data, tx_frcdisp, tx_dispval, tx_frcdata});
      for (int h = 0; gear && h < 2; h++) begin
        logic [51:0] e;
        int s;
        e = '0;
        s = (wmode == WIDTH_4B) ? 2 : 1;
        for (int k = 0; k < s; k++) begin
          e[12+10*k +: 10] = tx_data[10*(h*s+k) +: 10];
          e[8+k] = tx_frcdisp[h*s+k];
          e[4+k] = tx_dispval[h*s+k];
          e[k] = tx_frcdata[h*s+k];
        end
        txq.push_back(e);
      end
    end
    if (tx_valid === 1'h1) hm <= {tx_data, tx_frcdisp, tx_dispval, tx_frcdata};
    hd <= hm;
    bcnt <= (byp && src_en) ? bcnt + 1 : 0;
  end

  always @(posedge clk_sys) begin
    if (core_tx_valid === 1'h1 && !byp) begin
      chk("core_tx", txq.size() != 0 ? 56'(txq.pop_front()) : 'x,
        56'({core_tx_data, c_fd, c_dv, c_fr}));
    end
    if (rx_valid === 1'h1) begin
      chk("rx", rxq.size() != 0 ? rxq.pop_front() : 'x,
        {rx_data, rx_errdisp, rx_errcode, skp_add, skp_del});
    end
  end

  // bypass: two flops, every lane moves together
  always @(negedge clk_sys) begin
    if (bcnt > 3) chk("bypass", 56'(hd), 56'({core_tx_data, c_fd, c_dv, c_fr}));
  end

  initial begin
    void'($urandom(58));
    {rst_b, reg_wr, reg_rd, src_en, deskew_go, core_rx_valid, gear, byp} = '0;
    {reg_addr, reg_wdata, wmode, raw_mode} = '0;
    {core_rx_byte, core_rx_raw, core_rx_ctrl, core_rx_rundisp, r_ed, r_ec, r_sa, r_sd} = '0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'h1;
    rd(CTRL_ADDR, 32'(CTRL_RESET));
    rd(STAT_ADDR, 32'h4);
    rd(8'h08, 32'h0);
    $display("test registers done");
    for (int r = 0; r < 2; r++) begin
      for (int w = 0; w < 4; w++) begin
        raw_mode = r[0];
        ctrl(8'({r[0], w[1:0]}));
        rx_burst(10);
        repeat (2) @(posedge clk_sys);
      end
    end
    chk("rx_left", 56'h0, 56'(rxq.size()));
    $display("test rx lanes done");
    tx_run(8'h22, 4);
    tx_run(8'h0A, 8);
    tx_run(8'h09, 8);
    ctrl(8'h52);
    src_en <= 1'h1;
    repeat (20) @(posedge clk_sys);
    src_en <= 1'h0;
    // stop reading before leaving bypass, else the empty fifo underflows
    ctrl(8'h12);
    repeat (3) @(posedge clk_sys);
    $display("test bypass done");
    ctrl(8'h02);
    src_en <= 1'h1;
    repeat (12) @(posedge clk_sys);
    src_en <= 1'h0;
    repeat (3) @(posedge clk_sys);
    rd(STAT_ADDR, 32'h89);
    chk("tx_flags", 56'h9, 56'({t_fu, t_em, t_un, t_ov}));
    chk("deskew_ready", 56'h1, 56'(deskew_ready));
    wr(STAT_ADDR, 32'h1);
    rd(STAT_ADDR, 32'h88);
    txq.delete();
    $display("test overflow done");
    results();
  end
endmodule
`default_nettype wire
